// ===== verilog/mat_pkg.sv
`default_nettype none
package mat_pkg;
    // printed offsets 0xa0 and 0xa2: not all multiples of four, so they are indices
    localparam logic [7:0] MAT_IDX_WORD_ONE = 8'ha0;
    localparam logic [7:0] MAT_IDX_WORD_TWO = 8'ha2;
    localparam logic [31:0] MAT_ADDR_WORD_ONE = {22'h0, MAT_IDX_WORD_ONE, 2'h0};
    localparam logic [31:0] MAT_ADDR_WORD_TWO = {22'h0, MAT_IDX_WORD_TWO, 2'h0};
    localparam logic [31:0] MAT_RESET_WORD_ONE = 32'h0000_0000;
    localparam logic [31:0] MAT_RESET_WORD_TWO = 32'h0000_0000;
    localparam logic [1:0] MAT_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] MAT_HTRANS_SEQ = 2'h3;
    localparam logic [2:0] MAT_HSIZE_WORD = 3'h2;
    localparam logic [2:0] MAT_CL_CODE_SELECT = 3'h2;
    // field positions, word one
    localparam int MAT_W1_BRAKE_EXIT_LSB = 29;
    localparam int MAT_W1_GLITCH_LSB = 27;
    localparam int MAT_W1_QUICK_SPIN = 26;
    localparam int MAT_W1_STOP_PERSIST_LSB = 24;
    localparam int MAT_W1_RUN_PERSIST_LSB = 22;
    localparam int MAT_W1_TIMEOUT_LSB = 20;
    localparam int MAT_W1_HANDOFF_LSB = 17;
    localparam int MAT_W1_BRAKE_PERSIST_LSB = 15;
    localparam int MAT_W1_PROBE_LIMIT_LSB = 13;
    localparam int MAT_W1_PROBE_REPEAT_LSB = 11;
    localparam int MAT_W1_OL_CURRENT_LSB = 8;
    localparam int MAT_W1_OL_SPEED_LSB = 6;
    localparam int MAT_W1_OL_SLEW_LSB = 3;
    localparam int MAT_W1_REV_DECEL_LSB = 0;
    // field positions, word two
    localparam int MAT_W2_UNALIGNED_ACCEL_LSB = 6;
    localparam int MAT_W2_BRAKE_SLEW_LSB = 3;
    localparam int MAT_W2_PROBE_SELECT = 2;
    localparam int MAT_W2_BACKEMF_SELECT = 1;
    localparam int MAT_W2_FINE_RES = 0;
    // glitch filter widths in ns and derived cycles at 4 ns
    localparam int MAT_CLK_PERIOD_NS = 4;
    localparam int MAT_GLITCH_1_NS = 200;
    localparam int MAT_GLITCH_2_NS = 500;
    localparam int MAT_GLITCH_3_NS = 1000;
    localparam int MAT_GLITCH_1_CYC = (MAT_GLITCH_1_NS + MAT_CLK_PERIOD_NS - 1) / MAT_CLK_PERIOD_NS;
    localparam int MAT_GLITCH_2_CYC = (MAT_GLITCH_2_NS + MAT_CLK_PERIOD_NS - 1) / MAT_CLK_PERIOD_NS;
    localparam int MAT_GLITCH_3_CYC = (MAT_GLITCH_3_NS + MAT_CLK_PERIOD_NS - 1) / MAT_CLK_PERIOD_NS;
    localparam int MAT_GLITCH_CNT_W = 8;

    typedef struct packed {
        logic [1:0] brake_exit_band;
        logic [1:0] glitch_filter;
        logic quick_spin_detect_enable;
        logic [1:0] spin_detect_stop_persist;
        logic [1:0] spin_detect_run_persist;
        logic [1:0] spin_detect_timeout;
        logic [2:0] handoff_min_backemf;
        logic [1:0] brake_low_current_persist;
        logic [2:0] reverse_openloop_decel;
        logic [3:0] unaligned_closedloop_accel;
        logic [2:0] brake_bus_current_slew;
        logic probe_fine_resolution_enable;
    } mat_algo_cfg_t;

    typedef struct packed {
        logic [1:0] probe_current_code;
        logic [1:0] probe_repeat_code;
        logic probe_from_measure;
        logic [2:0] openloop_current_code;
        logic [1:0] openloop_speed_code;
        logic [2:0] openloop_slew_code;
        logic openloop_from_measure;
    } mat_param_sel_t;

    typedef enum logic [1:0] {
        MAT_DPH_IDLE = 2'b01,
        MAT_DPH_ACTIVE = 2'b10
    } mat_dphase_t;
endpackage
`default_nettype wire

// ===== verilog/mat_algo_tuning_regs.sv
// Register access over AHB-Lite was decided locally.
`default_nettype none
module mat_algo_tuning_regs
    import mat_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic speed_pin,
    input wire logic [1:0] normal_probe_current_code,
    input wire logic [1:0] normal_probe_repeat_code,
    input wire logic [2:0] normal_openloop_accel_code,
    input wire logic [2:0] normal_openloop_current_code,
    input wire logic [1:0] normal_handoff_speed_code,
    output mat_algo_cfg_t algo_cfg,
    output mat_param_sel_t param_sel,
    output logic speed_pin_filtered
);
    logic [31:0] algo_tuning_word_one;
    logic [31:0] algo_tuning_word_two;
    mat_dphase_t dphase;
    logic dph_write;
    logic [1:0] dph_reg;
    logic [1:0] next_rd_reg;
    logic sync_a;
    logic sync_b;
    logic [MAT_GLITCH_CNT_W-1:0] glitch_cnt;
    logic [MAT_GLITCH_CNT_W-1:0] glitch_limit;

    // one-hot register selector: bit 0 word one, bit 1 word two, zero unmapped
    function automatic logic [1:0] reg_decode(input logic [31:0] addr);
        logic [1:0] hit;
        hit = 2'b00;
        if (addr == MAT_ADDR_WORD_ONE) begin
            hit = 2'b01;
        end else if (addr == MAT_ADDR_WORD_TWO) begin
            hit = 2'b10;
        end
        return hit;
    endfunction

    function automatic logic [MAT_GLITCH_CNT_W-1:0] glitch_cycles(input logic [1:0] code);
        logic [MAT_GLITCH_CNT_W-1:0] c;
        case (code)
            2'h1: c = MAT_GLITCH_CNT_W'(MAT_GLITCH_1_CYC);
            2'h2: c = MAT_GLITCH_CNT_W'(MAT_GLITCH_2_CYC);
            2'h3: c = MAT_GLITCH_CNT_W'(MAT_GLITCH_3_CYC);
            default: c = '0;
        endcase
        return c;
    endfunction

    wire logic addr_valid = hsel && hready && (htrans == MAT_HTRANS_NONSEQ ||
        htrans == MAT_HTRANS_SEQ);

    // word-size accesses only decode; unmapped offsets stay inert
    always_comb begin
        next_rd_reg = 2'b00;
        if (addr_valid && hsize == MAT_HSIZE_WORD) begin
            next_rd_reg = reg_decode(haddr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase <= MAT_DPH_IDLE;
            dph_write <= 1'b0;
            dph_reg <= 2'b00;
        end else begin
            dphase <= addr_valid ? MAT_DPH_ACTIVE : MAT_DPH_IDLE;
            dph_write <= addr_valid && hwrite;
            dph_reg <= next_rd_reg;
        end
    end

    wire logic wr_active = (dphase == MAT_DPH_ACTIVE) && dph_write;

    // every bit, reserved included, is plain storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            algo_tuning_word_one <= MAT_RESET_WORD_ONE;
        end else if (wr_active && dph_reg[0]) begin
            algo_tuning_word_one <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            algo_tuning_word_two <= MAT_RESET_WORD_TWO;
        end else if (wr_active && dph_reg[1]) begin
            algo_tuning_word_two <= hwdata;
        end
    end

    // read data registered so hrdata comes from a flop; answer in the data phase
    // a read pipelined behind a write to the same word takes the landing data,
    // since the stored word only updates at this same edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_valid && !hwrite) begin
            if (wr_active && next_rd_reg != 2'b00 && dph_reg == next_rd_reg) begin
                hrdata <= hwdata;
            end else begin
                case (next_rd_reg)
                    2'b01: hrdata <= algo_tuning_word_one;
                    2'b10: hrdata <= algo_tuning_word_two;
                    default: hrdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // field outputs: registered copies, one cycle behind the stored words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            algo_cfg <= '0;
        end else begin
            algo_cfg.brake_exit_band <= algo_tuning_word_one[MAT_W1_BRAKE_EXIT_LSB +: 2];
            algo_cfg.glitch_filter <= algo_tuning_word_one[MAT_W1_GLITCH_LSB +: 2];
            algo_cfg.quick_spin_detect_enable <= algo_tuning_word_one[MAT_W1_QUICK_SPIN];
            algo_cfg.spin_detect_stop_persist <=
                algo_tuning_word_one[MAT_W1_STOP_PERSIST_LSB +: 2];
            algo_cfg.spin_detect_run_persist <=
                algo_tuning_word_one[MAT_W1_RUN_PERSIST_LSB +: 2];
            algo_cfg.spin_detect_timeout <= algo_tuning_word_one[MAT_W1_TIMEOUT_LSB +: 2];
            algo_cfg.handoff_min_backemf <= algo_tuning_word_one[MAT_W1_HANDOFF_LSB +: 3];
            algo_cfg.brake_low_current_persist <=
                algo_tuning_word_one[MAT_W1_BRAKE_PERSIST_LSB +: 2];
            algo_cfg.reverse_openloop_decel <=
                algo_tuning_word_one[MAT_W1_REV_DECEL_LSB +: 3];
            algo_cfg.unaligned_closedloop_accel <=
                algo_tuning_word_two[MAT_W2_UNALIGNED_ACCEL_LSB +: 4];
            algo_cfg.brake_bus_current_slew <=
                algo_tuning_word_two[MAT_W2_BRAKE_SLEW_LSB +: 3];
            algo_cfg.probe_fine_resolution_enable <= algo_tuning_word_two[MAT_W2_FINE_RES];
        end
    end

    // parameter-set muxes: measurement fields or the normal-operation inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            param_sel <= '0;
        end else begin
            param_sel.probe_from_measure <= algo_tuning_word_two[MAT_W2_PROBE_SELECT];
            param_sel.openloop_from_measure <= algo_tuning_word_two[MAT_W2_BACKEMF_SELECT];
            if (algo_tuning_word_two[MAT_W2_PROBE_SELECT]) begin
                param_sel.probe_current_code <=
                    algo_tuning_word_one[MAT_W1_PROBE_LIMIT_LSB +: 2];
                param_sel.probe_repeat_code <=
                    algo_tuning_word_one[MAT_W1_PROBE_REPEAT_LSB +: 2];
            end else begin
                param_sel.probe_current_code <= normal_probe_current_code;
                param_sel.probe_repeat_code <= normal_probe_repeat_code;
            end
            if (algo_tuning_word_two[MAT_W2_BACKEMF_SELECT]) begin
                // reserved current codes pass through unchanged; consumer must not use them
                param_sel.openloop_current_code <=
                    algo_tuning_word_one[MAT_W1_OL_CURRENT_LSB +: 3];
                param_sel.openloop_speed_code <=
                    algo_tuning_word_one[MAT_W1_OL_SPEED_LSB +: 2];
                param_sel.openloop_slew_code <=
                    algo_tuning_word_one[MAT_W1_OL_SLEW_LSB +: 3];
            end else begin
                param_sel.openloop_current_code <= normal_openloop_current_code;
                param_sel.openloop_speed_code <= normal_handoff_speed_code;
                param_sel.openloop_slew_code <= normal_openloop_accel_code;
            end
        end
    end

    // speed pin: two-flop synchroniser, then a width filter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= speed_pin;
            sync_b <= sync_a;
        end
    end

    assign glitch_limit = glitch_cycles(algo_tuning_word_one[MAT_W1_GLITCH_LSB +: 2]);

    // a new level is accepted only after it stands the full filter width
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            glitch_cnt <= '0;
            speed_pin_filtered <= 1'b0;
        end else if (sync_b == speed_pin_filtered) begin
            glitch_cnt <= '0;
        end else if (glitch_cnt >= glitch_limit) begin
            glitch_cnt <= '0;
            speed_pin_filtered <= sync_b;
        end else begin
            glitch_cnt <= glitch_cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/mat_algo_tuning_regs_properties.sv
`default_nettype none
module mat_algo_tuning_regs_properties
    import mat_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic speed_pin,
    input wire logic [1:0] normal_probe_current_code,
    input wire logic [1:0] normal_probe_repeat_code,
    input wire logic [2:0] normal_openloop_accel_code,
    input wire logic [2:0] normal_openloop_current_code,
    input wire logic [1:0] normal_handoff_speed_code,
    input wire mat_algo_cfg_t algo_cfg,
    input wire mat_param_sel_t param_sel,
    input wire logic speed_pin_filtered
);
    logic prev_pin;
    logic [8:0] stable_cnt;
    logic [31:0] wd_q, wd_qq;
    // saturating run length of the raw pin level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_pin <= 1'b0;
            stable_cnt <= 9'h000;
        end else begin
            prev_pin <= speed_pin;
            stable_cnt <= (speed_pin != prev_pin) ? 9'h000 :
                (stable_cnt == 9'h12c) ? stable_cnt : stable_cnt + 9'h001;
        end
    end
    // data phase value, aligned to when the field outputs follow it
    always_ff @(posedge hclk) begin
        wd_q <= hwdata;
        wd_qq <= wd_q;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence word_wr(logic [31:0] a);
        hsel && hready && hwrite && htrans == MAT_HTRANS_NONSEQ && hsize == MAT_HSIZE_WORD
            && haddr == a;
    endsequence
    word_one_map_a:
    assert property (word_wr(MAT_ADDR_WORD_ONE) |-> ##3
        {algo_cfg[26:11], algo_cfg[10:8]} == {wd_qq[30:15], wd_qq[2:0]}) else $error("w1 map");
    word_two_map_a:
    assert property (word_wr(MAT_ADDR_WORD_TWO) |-> ##3 algo_cfg[7:0] == {wd_qq[9:3], wd_qq[0]}
        && {param_sel[9], param_sel[0]} == wd_qq[2:1]) else $error("w2 map");
    probe_normal_a:
    assert property ($past(hresetn) && !param_sel.probe_from_measure |->
        param_sel[13:10] == {$past(normal_probe_current_code), $past(normal_probe_repeat_code)})
        else $error("probe source");
    openloop_normal_a:
    assert property ($past(hresetn) && !param_sel.openloop_from_measure |->
        param_sel.openloop_current_code == $past(normal_openloop_current_code)
        && param_sel.openloop_speed_code == $past(normal_handoff_speed_code)
        && param_sel.openloop_slew_code == $past(normal_openloop_accel_code))
        else $error("openloop source");
    bus_okay_a:
    assert property (hreadyout && !hresp) else $error("bus response");
    reset_value_a:
    assert property ($rose(hresetn) |-> hrdata == 32'h0 && algo_cfg == '0 && param_sel == '0)
        else $error("reset values");
    glitch_hold_a:
    assert property ($changed(speed_pin_filtered) && algo_cfg.glitch_filter == 2'h3 |->
        stable_cnt >= 9'h0fa) else $error("short pulse passed");
    glitch_settle_a:
    assert property (stable_cnt == 9'h104 |-> speed_pin_filtered == speed_pin)
        else $error("pin not followed");
endmodule
bind mat_algo_tuning_regs mat_algo_tuning_regs_properties i_mat_props (.*);
`default_nettype wire

// ===== testbench/mat_algo_tuning_regs_tb_top.sv
`default_nettype none
module mat_algo_tuning_regs_tb_top
    import mat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, speed_pin, hreadyout, hresp, speed_pin_filtered;
    logic [31:0] haddr, hwdata, hrdata, r, v, w;
    logic [1:0] htrans, normal_probe_current_code, normal_probe_repeat_code;
    logic [1:0] normal_handoff_speed_code;
    logic [2:0] hsize, normal_openloop_accel_code, normal_openloop_current_code;
    mat_algo_cfg_t algo_cfg;
    mat_param_sel_t param_sel;
    int failures = 0;
    int check_count = 0;
    int lim;
    mat_algo_tuning_regs i_mat_algo_tuning_regs (.hready(hreadyout), .*);
    initial forever #2 hclk = ~hclk;
    task automatic close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // entered just after a rising edge; leaves just after the data phase edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= MAT_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        close_out();
    end
    initial begin
        {hresetn, hsel, hwrite, speed_pin, htrans, haddr, hwdata} = '0;
        hsize = MAT_HSIZE_WORD;
        {normal_probe_current_code, normal_probe_repeat_code, normal_openloop_current_code,
            normal_handoff_speed_code, normal_openloop_accel_code} = 12'h4d6;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, MAT_ADDR_WORD_ONE, 32'h0);
        chk(r, MAT_RESET_WORD_ONE);
        xfer(1'b0, MAT_ADDR_WORD_TWO, 32'h0);
        chk(r, MAT_RESET_WORD_TWO);
        // nibble repeated across the word walks every code of every field
        for (int k = 0; k < 16; k++) begin
            v = {8{k[3:0]}};
            w = ~v;
            {normal_probe_current_code, normal_probe_repeat_code, normal_openloop_current_code,
                normal_handoff_speed_code, normal_openloop_accel_code} <= 12'(k * 419);
            xfer(1'b1, MAT_ADDR_WORD_ONE, v);
            xfer(1'b1, MAT_ADDR_WORD_TWO, w);
            xfer(1'b1, k[0] ? 32'h0000_0284 : 32'h0000_028c, 32'hffff_ffff);
            xfer(1'b0, MAT_ADDR_WORD_ONE, 32'h0);
            chk(r, v);
            xfer(1'b0, MAT_ADDR_WORD_TWO, 32'h0);
            chk(r, w);
            xfer(1'b0, 32'h0000_0284, 32'h0);
            chk(r, 32'h0);
            chk(32'(algo_cfg), 32'({v[30:15], v[2:0], w[9:3], w[0]}));
            chk(32'(param_sel), 32'({w[2] ? v[14:11] : {normal_probe_current_code,
                normal_probe_repeat_code}, w[2], w[1] ? v[10:3] : {normal_openloop_current_code,
                normal_handoff_speed_code, normal_openloop_accel_code}, w[1]}));
        end
        for (int c = 0; c < 4; c++) begin
            lim = (c == 1) ? MAT_GLITCH_1_CYC : (c == 2) ? MAT_GLITCH_2_CYC :
                (c == 3) ? MAT_GLITCH_3_CYC : 0;
            xfer(1'b1, MAT_ADDR_WORD_ONE, 32'(c) << MAT_W1_GLITCH_LSB);
            repeat (2) @(posedge hclk);
            if (lim > 0) begin
                speed_pin <= ~speed_pin;
                repeat (lim / 2) @(posedge hclk);
                speed_pin <= ~speed_pin;
                repeat (4) @(posedge hclk);
                chk(32'(speed_pin_filtered), 32'(speed_pin));
                repeat (lim + 8) @(posedge hclk);
            end
            speed_pin <= ~speed_pin;
            repeat (lim + 8) @(posedge hclk);
            chk(32'(speed_pin_filtered), 32'(speed_pin));
        end
        close_out();
    end
endmodule
`default_nettype wire
